// ---- shared/ema_params.svh ----
// constants of the engine to mac stream adapter
`ifndef EMA_PARAMS_SVH
`define EMA_PARAMS_SVH

`define EMA_DATA_W 256
`define EMA_BUF_DEPTH 512
`define EMA_BUF_WIDTH 258
`define EMA_FILL_W 10
`define EMA_PKT_CNT_W 10
`define EMA_UNUSED_W 5
`define EMA_UNUSED_SEL_BIT 3
`define EMA_UNUSED_NARROW 5'h04
`define EMA_UNUSED_WIDE 5'h0A
`define EMA_RX_FILL_LIMIT 10'h0E0

`endif

// ---- shared/ema_pkg.sv ----
// types of the engine to mac stream adapter
`include "ema_params.svh"

package ema_pkg;

	typedef enum logic [1:0] {
		tx_state_waiting,
		tx_state_packet_accounting,
		tx_state_transferring
	} ema_tx_seq_type;

	typedef enum logic [1:0] {
		rx_state_waiting,
		rx_state_transferring,
		rx_state_discarding
	} ema_rx_seq_type;

	typedef struct packed {
		logic unused_bit;
		logic last;
		logic [`EMA_DATA_W-1:0] data;
	} ema_tx_entry_type;

	typedef struct packed {
		logic first;
		logic last;
		logic [`EMA_DATA_W-1:0] data;
	} ema_rx_entry_type;

	typedef struct packed {
		logic [`EMA_PKT_CNT_W-1:0] written_packet_count;
		logic [`EMA_PKT_CNT_W-1:0] written_gray;
	} ema_eng_regs_type;

	typedef struct packed {
		ema_tx_seq_type tx_sequencer_state;
		logic [`EMA_PKT_CNT_W-1:0] forwarded_packet_count;
		logic [`EMA_PKT_CNT_W-1:0] written_gray_s1;
		logic [`EMA_PKT_CNT_W-1:0] written_gray_s2;
		logic [`EMA_DATA_W-1:0] word;
		logic [`EMA_UNUSED_W-1:0] unused_bytes;
		logic valid;
		logic first;
		logic last;
	} ema_tx_regs_type;

	typedef struct packed {
		ema_rx_seq_type rx_sequencer_state;
		logic push;
		ema_rx_entry_type push_word;
	} ema_rx_regs_type;

endpackage

// ---- hw/ema_engine_mac_adapter.sv ----
// engine to mac stream adapter: async packet buffers, tx and rx sequencers
// Summary of operation
// R1: three clock domains, one async buffer per direction
// R2: each buffer holds 512 words of 258 bits
// R3: engine writes tx buffer, reads rx buffer directly
// R4: engine counts packet ends, count crosses to tx
// R5: forwarded count rises at each packet start
// R6: waiting packets equal synced written minus forwarded
// R7: only bit 3 of unused bytes stored
// R8: leave idle on waiting packets and buffer data
// R9: accounting lasts one cycle, then transferring
// R10: pop only when busy and mac accepts
// R11: buffers show read data with the pop
// R12: valid rises with first word, holds till end
// R13: first flag clears after the word accepted
// R14: mac pause stops pops and holds the word
// R15: end word accepted returns idle, drops valid
// R16: fill below 224 words starts transferring a packet
// R17: rx push and word delayed one clock
// R18: transferring ends on valid end of packet
// R19: no room discards whole packet, no pushes
// R20: written count crosses gray coded, two flops
// R21: reset clears counters, buffers, machines, strobes

`include "ema_params.svh"

module ema_async_fifo #(
	parameter int WIDTH = `EMA_BUF_WIDTH,
	parameter int DEPTH = `EMA_BUF_DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	// write side
	input wire logic wr_clk,
	input wire logic wr_rst,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_word,
	output logic full,
	output logic [AW:0] fill_level,
	// read side
	input wire logic rd_clk,
	input wire logic rd_rst,
	input wire logic pop,
	output logic [WIDTH-1:0] pop_word,
	output logic no_data
);

	typedef struct packed {
		logic [AW:0] bin;
		logic [AW:0] gray;
		logic [AW:0] far_gray_s1;
		logic [AW:0] far_gray_s2;
	} ema_fifo_side_type;

	ema_fifo_side_type wr_q, wr_d, rd_q, rd_d;
	logic [WIDTH-1:0] mem [DEPTH];

	function automatic logic [AW:0] gray_to_bin(input logic [AW:0] g);
		logic [AW:0] b;
		b[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// pointers cross as gray code so a sample is never torn between two values
	assign fill_level = wr_q.bin - gray_to_bin(wr_q.far_gray_s2);
	assign full = (fill_level == (AW+1)'(DEPTH));
	assign no_data = (rd_q.gray == rd_q.far_gray_s2);
	// show-ahead: the head word is on the output before the pop that takes it
	assign pop_word = mem[rd_q.bin[AW-1:0]]; // see R11

	always_comb begin
		wr_d = wr_q;
		wr_d.far_gray_s1 = rd_q.gray;
		wr_d.far_gray_s2 = wr_q.far_gray_s1;
		if (push && !full) begin
			wr_d.bin = wr_q.bin + 1'b1;
			wr_d.gray = wr_d.bin ^ (wr_d.bin >> 1);
		end
		rd_d = rd_q;
		rd_d.far_gray_s1 = wr_q.gray;
		rd_d.far_gray_s2 = rd_q.far_gray_s1;
		if (pop && !no_data) begin
			rd_d.bin = rd_q.bin + 1'b1;
			rd_d.gray = rd_d.bin ^ (rd_d.bin >> 1);
		end
	end

	// pointer reset empties the buffer; the storage itself keeps stale words
	always_ff @(posedge wr_clk or posedge wr_rst) begin // see R21
		if (wr_rst) begin
			wr_q <= '0;
		end else begin
			wr_q <= wr_d;
		end
	end

	always_ff @(posedge rd_clk or posedge rd_rst) begin
		if (rd_rst) begin
			rd_q <= '0;
		end else begin
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge wr_clk) begin
		if (push && !full) begin
			mem[wr_q.bin[AW-1:0]] <= push_word;
		end
	end

endmodule // ema_async_fifo

module ema_engine_mac_adapter #(
	parameter int BUF_DEPTH = `EMA_BUF_DEPTH
) (
	// engine clock and common reset
	input wire logic clk,
	input wire logic rst,
	// engine transmit write port
	input wire logic tx_write,
	input wire logic [`EMA_DATA_W-1:0] tx_word,
	input wire logic tx_last,
	input wire logic [`EMA_UNUSED_W-1:0] last_word_unused_bytes,
	output logic tx_buffer_full,
	// engine receive read port
	input wire logic rx_read,
	output logic [`EMA_DATA_W-1:0] rx_word,
	output logic rx_word_first,
	output logic rx_word_last,
	output logic rx_no_data,
	// mac transmit stream
	input wire logic mac_tx_clock,
	input wire logic mac_tx_accept,
	output logic [`EMA_DATA_W-1:0] mac_tx_word,
	output logic mac_tx_word_valid,
	output logic mac_tx_packet_first,
	output logic mac_tx_packet_last,
	output logic [`EMA_UNUSED_W-1:0] mac_tx_unused_bytes,
	// mac receive stream
	input wire logic mac_rx_clock,
	input wire logic mac_rx_word_valid,
	input wire logic mac_rx_packet_first,
	input wire logic mac_rx_packet_last,
	input wire logic [`EMA_DATA_W-1:0] mac_rx_word
);

	ema_pkg::ema_eng_regs_type eng_q, eng_d;
	ema_pkg::ema_tx_regs_type tx_q, tx_d;
	ema_pkg::ema_rx_regs_type rx_q, rx_d;
	ema_pkg::ema_tx_entry_type tx_entry_in, tx_entry_out;
	ema_pkg::ema_rx_entry_type rx_entry_out;
	logic tx_buffer_no_data;
	logic tx_buffer_pop;
	logic [`EMA_FILL_W-1:0] rx_buffer_fill_level;
	logic [`EMA_PKT_CNT_W-1:0] written_count_synced;
	logic [`EMA_PKT_CNT_W-1:0] waiting_packet_count;
	logic tx_end_taken;

	function automatic logic [`EMA_PKT_CNT_W-1:0] cnt_gray_to_bin(
		input logic [`EMA_PKT_CNT_W-1:0] g);
		logic [`EMA_PKT_CNT_W-1:0] b;
		b[`EMA_PKT_CNT_W-1] = g[`EMA_PKT_CNT_W-1];
		for (int i = `EMA_PKT_CNT_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// the two codes differ in bit 3, so one stored bit restores either
	assign tx_entry_in.unused_bit = last_word_unused_bytes[`EMA_UNUSED_SEL_BIT]; // see R7
	assign tx_entry_in.last = tx_last;
	assign tx_entry_in.data = tx_word;

	ema_async_fifo #(
		.WIDTH($bits(ema_pkg::ema_tx_entry_type)),
		.DEPTH(BUF_DEPTH)
	) tx_packet_buffer ( // see R1, R2, R3
		.wr_clk(clk),
		.wr_rst(rst),
		.push(tx_write),
		.push_word(tx_entry_in),
		.full(tx_buffer_full),
		.fill_level(),
		.rd_clk(mac_tx_clock),
		.rd_rst(rst),
		.pop(tx_buffer_pop),
		.pop_word(tx_entry_out),
		.no_data(tx_buffer_no_data)
	);

	ema_async_fifo #(
		.WIDTH($bits(ema_pkg::ema_rx_entry_type)),
		.DEPTH(BUF_DEPTH)
	) rx_packet_buffer ( // see R1, R2, R3
		.wr_clk(mac_rx_clock),
		.wr_rst(rst),
		.push(rx_q.push),
		.push_word(rx_q.push_word),
		.full(),
		.fill_level(rx_buffer_fill_level),
		.rd_clk(clk),
		.rd_rst(rst),
		.pop(rx_read),
		.pop_word(rx_entry_out),
		.no_data(rx_no_data)
	);

	assign rx_word = rx_entry_out.data;
	assign rx_word_first = rx_entry_out.first;
	assign rx_word_last = rx_entry_out.last;

	// engine domain: count packet ends as they enter the buffer
	always_comb begin
		eng_d = eng_q;
		if (tx_write && tx_last && !tx_buffer_full) begin
			eng_d.written_packet_count = eng_q.written_packet_count + 1'b1; // see R4
		end
		eng_d.written_gray = eng_d.written_packet_count ^ (eng_d.written_packet_count >> 1); // see R20
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eng_q <= '0;
		end else begin
			eng_q <= eng_d;
		end
	end

	a_written_count: assert property (@(posedge clk) disable iff (rst) // see R4
		tx_write && tx_last && !tx_buffer_full |=>
		eng_q.written_packet_count == $past(eng_q.written_packet_count) + 1'b1)
		else $error("written packet count missed a packet end");

	// tx domain: a packet is released only once its end is in the buffer
	assign written_count_synced = cnt_gray_to_bin(tx_q.written_gray_s2);
	assign waiting_packet_count = written_count_synced - tx_q.forwarded_packet_count; // see R6
	assign tx_end_taken = tx_q.valid && tx_q.last && mac_tx_accept;
	// no pop after the end word, so the next packet stays in the buffer
	assign tx_buffer_pop = (tx_q.tx_sequencer_state != ema_pkg::tx_state_waiting)
		&& mac_tx_accept && !tx_buffer_no_data && !(tx_q.valid && tx_q.last); // see R10, R14

	always_comb begin
		tx_d = tx_q;
		tx_d.written_gray_s1 = eng_q.written_gray; // see R20
		tx_d.written_gray_s2 = tx_q.written_gray_s1;
		unique case (tx_q.tx_sequencer_state)
			ema_pkg::tx_state_waiting: begin
				if (waiting_packet_count != '0 && !tx_buffer_no_data) begin // see R8
					tx_d.tx_sequencer_state = ema_pkg::tx_state_packet_accounting;
				end
			end
			ema_pkg::tx_state_packet_accounting: begin
				tx_d.forwarded_packet_count = tx_q.forwarded_packet_count + 1'b1; // see R5, R9
				tx_d.tx_sequencer_state = ema_pkg::tx_state_transferring;
			end
			ema_pkg::tx_state_transferring: begin
				if (tx_end_taken) begin
					tx_d.tx_sequencer_state = ema_pkg::tx_state_waiting; // see R15
				end
			end
			default: begin
				tx_d.tx_sequencer_state = ema_pkg::tx_state_waiting;
			end
		endcase
		if (tx_buffer_pop) begin
			tx_d.word = tx_entry_out.data; // see R10
			tx_d.unused_bytes = tx_entry_out.unused_bit ? `EMA_UNUSED_WIDE : `EMA_UNUSED_NARROW;
			tx_d.last = tx_entry_out.last;
			tx_d.valid = 1'b1; // see R12
			tx_d.first = !tx_q.valid; // see R13
		end else if (tx_q.valid && mac_tx_accept) begin
			tx_d.valid = 1'b0; // see R15
			tx_d.first = 1'b0;
			tx_d.last = 1'b0;
		end
	end

	always_ff @(posedge mac_tx_clock or posedge rst) begin
		if (rst) begin
			tx_q <= '0; // see R21
		end else begin
			tx_q <= tx_d;
		end
	end

	assign mac_tx_word = tx_q.word;
	assign mac_tx_word_valid = tx_q.valid;
	assign mac_tx_packet_first = tx_q.first;
	assign mac_tx_packet_last = tx_q.last;
	assign mac_tx_unused_bytes = tx_q.unused_bytes;

	a_tx_leave_idle: assert property (@(posedge mac_tx_clock) disable iff (rst) // see R8
		tx_q.tx_sequencer_state == ema_pkg::tx_state_packet_accounting |->
		$past(waiting_packet_count) != '0 && !$past(tx_buffer_no_data))
		else $error("tx left idle with no complete packet");

	a_tx_accounting_once: assert property (@(posedge mac_tx_clock) disable iff (rst) // see R9
		tx_q.tx_sequencer_state == ema_pkg::tx_state_packet_accounting |=>
		tx_q.tx_sequencer_state == ema_pkg::tx_state_transferring
		&& tx_q.forwarded_packet_count == $past(tx_q.forwarded_packet_count) + 1'b1)
		else $error("accounting state did not last one cycle");

	a_tx_pop_gate: assert property (@(posedge mac_tx_clock) disable iff (rst) // see R10
		tx_buffer_pop |=> tx_q.valid && tx_q.word == $past(tx_entry_out.data))
		else $error("popped word not loaded onto the mac bus");

	a_tx_pause_hold: assert property (@(posedge mac_tx_clock) disable iff (rst) // see R14
		tx_q.valid && !mac_tx_accept |=> tx_q.valid && $stable(tx_q.word) && $stable(tx_q.last))
		else $error("tx word changed while the mac paused");

	a_tx_first_clear: assert property (@(posedge mac_tx_clock) disable iff (rst) // see R13
		tx_q.valid && tx_q.first && mac_tx_accept |=> !tx_q.first)
		else $error("first flag stayed after acceptance");

	a_tx_end_idle: assert property (@(posedge mac_tx_clock) disable iff (rst) // see R15
		tx_end_taken |=> !tx_q.valid
		&& tx_q.tx_sequencer_state == ema_pkg::tx_state_waiting)
		else $error("tx did not finish after end word");

	a_tx_valid_steady: assert property (@(posedge mac_tx_clock) disable iff (rst) // see R12
		tx_q.valid && !tx_q.last |=> tx_q.valid)
		else $error("valid dropped inside a packet");

	// rx domain: packets are admitted whole or discarded whole
	always_comb begin
		rx_d = rx_q;
		rx_d.push = 1'b0;
		rx_d.push_word.first = mac_rx_packet_first; // see R17
		rx_d.push_word.last = mac_rx_packet_last;
		rx_d.push_word.data = mac_rx_word;
		unique case (rx_q.rx_sequencer_state)
			ema_pkg::rx_state_waiting: begin
				if (mac_rx_word_valid && mac_rx_packet_first) begin
					if (rx_buffer_fill_level < `EMA_RX_FILL_LIMIT) begin
						rx_d.push = 1'b1; // see R16
						if (!mac_rx_packet_last) begin
							rx_d.rx_sequencer_state = ema_pkg::rx_state_transferring;
						end
					end else if (!mac_rx_packet_last) begin
						rx_d.rx_sequencer_state = ema_pkg::rx_state_discarding; // see R19
					end
				end
			end
			ema_pkg::rx_state_transferring: begin
				rx_d.push = mac_rx_word_valid; // see R17
				if (mac_rx_word_valid && mac_rx_packet_last) begin
					rx_d.rx_sequencer_state = ema_pkg::rx_state_waiting; // see R18
				end
			end
			ema_pkg::rx_state_discarding: begin
				if (mac_rx_word_valid && mac_rx_packet_last) begin
					rx_d.rx_sequencer_state = ema_pkg::rx_state_waiting; // see R19
				end
			end
			default: begin
				rx_d.rx_sequencer_state = ema_pkg::rx_state_waiting;
			end
		endcase
	end

	always_ff @(posedge mac_rx_clock or posedge rst) begin
		if (rst) begin
			rx_q <= '0; // see R21
		end else begin
			rx_q <= rx_d;
		end
	end

	a_rx_push_delay: assert property (@(posedge mac_rx_clock) disable iff (rst) // see R17
		rx_q.rx_sequencer_state == ema_pkg::rx_state_transferring |=>
		rx_q.push == $past(mac_rx_word_valid) && rx_q.push_word.data == $past(mac_rx_word))
		else $error("rx push not one clock behind mac valid");

	a_rx_start_room: assert property (@(posedge mac_rx_clock) disable iff (rst) // see R16
		rx_q.rx_sequencer_state == ema_pkg::rx_state_waiting && mac_rx_word_valid
		&& mac_rx_packet_first && !mac_rx_packet_last
		&& rx_buffer_fill_level < `EMA_RX_FILL_LIMIT |=>
		rx_q.push && rx_q.rx_sequencer_state == ema_pkg::rx_state_transferring)
		else $error("rx packet with room not admitted");

	a_rx_end_idle: assert property (@(posedge mac_rx_clock) disable iff (rst) // see R18
		rx_q.rx_sequencer_state != ema_pkg::rx_state_waiting
		&& mac_rx_word_valid && mac_rx_packet_last |=>
		rx_q.rx_sequencer_state == ema_pkg::rx_state_waiting)
		else $error("rx did not return idle at packet end");

	a_rx_discard_quiet: assert property (@(posedge mac_rx_clock) disable iff (rst) // see R19
		rx_q.rx_sequencer_state == ema_pkg::rx_state_discarding |=> !rx_q.push)
		else $error("discarded packet pushed into buffer");

endmodule // ema_engine_mac_adapter

// ---- bench/ema_mac_model.sv ----
// behavioural model of the mac transmit and receive stream ports
`include "ema_params.svh"

module ema_mac_model (
	// mac clocks
	input wire logic mac_tx_clock,
	input wire logic mac_rx_clock,
	// scenario control
	input wire logic slow,
	// transmit stream
	output logic mac_tx_accept,
	// receive stream
	output logic mac_rx_word_valid,
	output logic mac_rx_packet_first,
	output logic mac_rx_packet_last,
	output logic [`EMA_DATA_W-1:0] mac_rx_word
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] pause_lfsr = 8'hA5;

	initial begin
		mac_tx_accept = 1'b0;
		mac_rx_word_valid = 1'b0;
		mac_rx_packet_first = 1'b0;
		mac_rx_packet_last = 1'b0;
		mac_rx_word = '0;
	end

	// pauses come at random so the adapter sees stalls on first, middle and end words
	always @(posedge mac_tx_clock) begin
		#1;
		pause_lfsr = {pause_lfsr[6:0], pause_lfsr[7] ^ pause_lfsr[5] ^ pause_lfsr[4] ^ pause_lfsr[3]};
		mac_tx_accept = !slow || pause_lfsr[0];
	end

	// the receive side cannot be stalled, words come back to back
	task automatic send_rx(input int n, input logic [31:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge mac_rx_clock);
			#1;
			mac_rx_word_valid = 1'b1;
			mac_rx_packet_first = (i == 0);
			mac_rx_packet_last = (i == n - 1);
			mac_rx_word = {8{base + i[31:0]}};
		end
		@(posedge mac_rx_clock);
		#1;
		mac_rx_word_valid = 1'b0;
		mac_rx_packet_first = 1'b0;
		mac_rx_packet_last = 1'b0;
		// released data must not keep looking like the last word
		mac_rx_word = ~mac_rx_word;
	endtask
endmodule // ema_mac_model

// ---- bench/tb.sv ----
// self-checking testbench of the engine to mac stream adapter
`include "ema_params.svh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic mac_tx_clock = 1'b0;
	logic mac_rx_clock;
	logic rst = 1'b1;
	logic tx_write = 1'b0;
	logic [`EMA_DATA_W-1:0] tx_word = '0;
	logic tx_last = 1'b0;
	logic [`EMA_UNUSED_W-1:0] last_word_unused_bytes = '0;
	logic tx_buffer_full;
	logic rx_read = 1'b0;
	logic [`EMA_DATA_W-1:0] rx_word;
	logic rx_word_first;
	logic rx_word_last;
	logic rx_no_data;
	logic mac_tx_accept;
	logic [`EMA_DATA_W-1:0] mac_tx_word;
	logic mac_tx_word_valid;
	logic mac_tx_packet_first;
	logic mac_tx_packet_last;
	logic [`EMA_UNUSED_W-1:0] mac_tx_unused_bytes;
	logic mac_rx_word_valid;
	logic mac_rx_packet_first;
	logic mac_rx_packet_last;
	logic [`EMA_DATA_W-1:0] mac_rx_word;
	logic slow = 1'b0;
	logic reading = 1'b0;
	logic [31:0] seed = 32'h00000006;
	int num_errors = 0;
	int checked = 0;
	logic [263:0] txq[$];
	ema_pkg::ema_rx_entry_type rxq[$];
	logic [263:0] snap;
	logic [263:0] held_snap;
	logic held = 1'b0;
	ema_pkg::ema_rx_entry_type rx_got;

	always #20 clk = ~clk;
	always #24 mac_tx_clock = ~mac_tx_clock;
	initial begin
		mac_rx_clock = 1'b0;
		#9;
		forever #24 mac_rx_clock = ~mac_rx_clock;
	end

	ema_engine_mac_adapter ema_engine_mac_adapter_i (.clk(clk), .rst(rst), .tx_write(tx_write),
		.tx_word(tx_word), .tx_last(tx_last), .last_word_unused_bytes(last_word_unused_bytes),
		.tx_buffer_full(tx_buffer_full), .rx_read(rx_read), .rx_word(rx_word),
		.rx_word_first(rx_word_first), .rx_word_last(rx_word_last), .rx_no_data(rx_no_data),
		.mac_tx_clock(mac_tx_clock), .mac_tx_accept(mac_tx_accept), .mac_tx_word(mac_tx_word),
		.mac_tx_word_valid(mac_tx_word_valid), .mac_tx_packet_first(mac_tx_packet_first),
		.mac_tx_packet_last(mac_tx_packet_last), .mac_tx_unused_bytes(mac_tx_unused_bytes),
		.mac_rx_clock(mac_rx_clock), .mac_rx_word_valid(mac_rx_word_valid),
		.mac_rx_packet_first(mac_rx_packet_first), .mac_rx_packet_last(mac_rx_packet_last),
		.mac_rx_word(mac_rx_word));

	ema_mac_model ema_mac_model_i (.mac_tx_clock(mac_tx_clock), .mac_rx_clock(mac_rx_clock),
		.slow(slow), .mac_tx_accept(mac_tx_accept), .mac_rx_word_valid(mac_rx_word_valid),
		.mac_rx_packet_first(mac_rx_packet_first), .mac_rx_packet_last(mac_rx_packet_last),
		.mac_rx_word(mac_rx_word));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic conclude();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cmp_tx(input string name, input logic [263:0] exp, input logic [263:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cmp_rx(input string name, input ema_pkg::ema_rx_entry_type exp,
		input ema_pkg::ema_rx_entry_type got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cmp_flag(input string name, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask

	// engine writes a packet; the code is held on every word so each word's restored code is known
	task automatic send_tx(input int n, input logic [4:0] code);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			tx_write = 1'b1;
			tx_word = {8{rnd()}};
			tx_last = (i == n - 1);
			last_word_unused_bytes = code;
			txq.push_back({1'b1, i == 0, i == n - 1, code, tx_word});
		end
	endtask

	task automatic end_tx();
		@(posedge clk);
		#1;
		tx_write = 1'b0;
		tx_last = 1'b0;
	endtask

	task automatic rx_pkt(input int n, input bit kept);
		logic [31:0] base;
		base = rnd();
		if (kept)
			for (int i = 0; i < n; i++)
				rxq.push_back({i == 0, i == n - 1, {8{base + i[31:0]}}});
		ema_mac_model_i.send_rx(n, base);
	endtask

	task automatic wait_empty(input string what);
		int i;
		for (i = 0; i < 20000 && (txq.size() != 0 || rxq.size() != 0); i++)
			@(posedge clk);
		if (i == 20000) begin
			num_errors++;
			conclude();
		end else begin
			$display("%s test done", what);
		end
	endtask

	// transmit watcher: accepted words against notes, paused words must stand
	always @(posedge mac_tx_clock) begin
		snap = {mac_tx_word_valid, mac_tx_packet_first, mac_tx_packet_last, mac_tx_unused_bytes,
			mac_tx_word};
		if (held)
			cmp_tx("tx held word", held_snap, snap);
		held = (mac_tx_word_valid === 1'b1 && mac_tx_accept === 1'b0);
		held_snap = snap;
		if (mac_tx_word_valid === 1'b1 && mac_tx_accept === 1'b1) begin
			if (txq.size() == 0) begin
				num_errors++;
				$display("wrong value tx word expected none seen %h", snap);
			end else
				cmp_tx("tx word", txq.pop_front(), snap);
		end
	end

	// receive watcher on the engine read port
	always @(posedge clk) begin
		if (rx_read === 1'b1 && rx_no_data === 1'b0) begin
			rx_got = {rx_word_first, rx_word_last, rx_word};
			if (rxq.size() == 0) begin
				num_errors++;
				$display("wrong value rx word expected none seen %h", rx_got);
			end else
				cmp_rx("rx word", rxq.pop_front(), rx_got);
		end
	end

	always @(posedge clk) begin
		#1;
		rx_read = reading & (rnd() > 32'h7FFFFFFF);
	end

	initial begin
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		cmp_flag("tx buffer full", 1'b0, tx_buffer_full);
		cmp_flag("rx no data", 1'b1, rx_no_data);
		cmp_flag("tx valid", 1'b0, mac_tx_word_valid);
		send_tx(1, `EMA_UNUSED_NARROW);
		send_tx(3, `EMA_UNUSED_WIDE);
		send_tx(2, `EMA_UNUSED_NARROW);
		end_tx();
		wait_empty("tx steady");
		// one packet as deep as the buffer: nothing leaves before its end, so it fills exactly
		send_tx(`EMA_BUF_DEPTH, `EMA_UNUSED_WIDE);
		end_tx();
		cmp_flag("tx buffer full", 1'b1, tx_buffer_full);
		wait_empty("tx full");
		slow = 1'b1;
		send_tx(5, `EMA_UNUSED_WIDE);
		send_tx(4, `EMA_UNUSED_NARROW);
		send_tx(1, `EMA_UNUSED_WIDE);
		end_tx();
		wait_empty("tx paused");
		// fill past the admission limit, then a packet that must vanish
		rx_pkt(1, 1'b1);
		rx_pkt(230, 1'b1);
		repeat (4) @(posedge mac_rx_clock);
		rx_pkt(3, 1'b0);
		reading = 1'b1;
		wait_empty("rx discard");
		rx_pkt(4, 1'b1);
		wait_empty("rx admit");
		conclude();
	end
endmodule // tb
